// ### hdl/rtcfg_consts.vh
// constants for the retimer channel transmit configuration register bank
`ifndef RTCFG_CONSTS_VH
`define RTCFG_CONSTS_VH
`define RTCFG_ADDR_CH_RESET 8'h00
`define RTCFG_ADDR_DEEMPH 8'h15
`define RTCFG_ADDR_SWING 8'h2d
`define RTCFG_ADDR_OVR_CTRL 8'h2f
`define RTCFG_ADDR_START_IDX 8'h39
`define RTCFG_ADDR_TABLE_LO 8'h40
`define RTCFG_ADDR_TABLE_HI 8'h5f
`define RTCFG_ADDR_SELECT 8'hff
`define RTCFG_BIT_CH_RESET 2
`define RTCFG_BIT_OVR_EN 3
`define RTCFG_BIT_DEEMPH_RANGE 6
`define RTCFG_BIT_SEL_CHAN 2
`define RTCFG_BIT_SEL_BCAST 3
`define RTCFG_SEL_CH_MSB 1
`define RTCFG_SWING_MSB 2
`define RTCFG_DEM_MSB 2
`define RTCFG_START_IDX_MSB 4
`define RTCFG_RST_REG 8'h00
`define RTCFG_RST_SELECT 8'h00
`define RTCFG_DEFAULT_START_IDX 5'h00
`endif

// ### hdl/rtcfg_regs.v
// register bank for per-channel transmit and adaptation configuration
`timescale 1ns/1ps
`default_nettype none
`include "rtcfg_consts.vh"
module rtcfg_regs #(
  parameter NCH = 4 // number of channels
) (
  input wire ref_clk_i, // system clock, 125 MHz
  input wire resetn_i, // async reset, active low (power-up)
  input wire wr_en_i, // write strobe, one cycle
  input wire [7:0] addr_i, // register address
  input wire [7:0] wdata_i, // write data
  output reg [7:0] rdata_o, // read data of addr_i, registered
  output reg [5*NCH-1:0] start_idx_o, // per channel adaptation start index
  output reg [8*NCH-1:0] start_boost_o, // per channel boost string at start index
  output reg [3*NCH-1:0] swing_code_o, // per channel swing code, 0.6 V + 0.1 V * code
  output reg [4*NCH-1:0] deemph_sel_o, // per channel {range, code}
  output reg [4*NCH-1:0] deemph_step_o // per channel de-emphasis step 0..14
);

  // shared select register; the only shared location that this block keeps
  // bit 2 opens the channel space, bit 3 then widens writes to every channel
  reg [7:0] select_ff; // bits 1:0 channel, bit 2 channel space, bit 3 broadcast
  wire chan_space = select_ff[`RTCFG_BIT_SEL_CHAN]; // channel set targeted
  // broadcast only counts while the channel space is open
  wire bcast = chan_space & select_ff[`RTCFG_BIT_SEL_BCAST];
  // reads always come from this channel, even while broadcast writes are on
  wire [1:0] cur_ch = select_ff[`RTCFG_SEL_CH_MSB:0];

  // default boost table, stage0..3 two bits each, stage0 in the top bits
  // one function feeds power-up and channel reset, so they cannot drift apart
  function [7:0] dflt_boost;
    input [4:0] i; // table entry, 0 is the one at 0x40
    begin
      case (i)
        5'h00: dflt_boost = 8'h00; // stages 0000
        5'h01: dflt_boost = 8'h01; // 0001
        5'h02: dflt_boost = 8'h04; // 0010
        5'h03: dflt_boost = 8'h10; // 0100
        5'h04: dflt_boost = 8'h40; // 1000
        5'h05: dflt_boost = 8'h08; // 0020
        5'h06: dflt_boost = 8'h02; // 0002
        5'h07: dflt_boost = 8'h80; // 2000
        5'h08: dflt_boost = 8'h03; // 0003
        5'h09: dflt_boost = 8'h0c; // 0030
        5'h0a: dflt_boost = 8'h30; // 0300
        5'h0b: dflt_boost = 8'h41; // 1001
        5'h0c: dflt_boost = 8'h50; // 1100
        5'h0d: dflt_boost = 8'hc0; // 3000
        5'h0e: dflt_boost = 8'h60; // 1200
        5'h0f: dflt_boost = 8'h90; // 2100
        5'h10: dflt_boost = 8'h88; // 2020
        5'h11: dflt_boost = 8'h82; // 2002
        5'h12: dflt_boost = 8'ha0; // 2200
        5'h13: dflt_boost = 8'h46; // 1012
        5'h14: dflt_boost = 8'h52; // 1102
        5'h15: dflt_boost = 8'h8c; // 2030
        5'h16: dflt_boost = 8'hb0; // 2300
        5'h17: dflt_boost = 8'hc8; // 3020
        5'h18: dflt_boost = 8'h57; // 1113
        5'h19: dflt_boost = 8'h5d; // 1131
        5'h1a: dflt_boost = 8'h69; // 1221
        5'h1b: dflt_boost = 8'h75; // 1311
        5'h1c: dflt_boost = 8'hd5; // 3111
        5'h1d: dflt_boost = 8'h99; // 2121
        5'h1e: dflt_boost = 8'h96; // 2112
        default: dflt_boost = 8'ha5; // 2211, last entry
      endcase
    end
  endfunction

  // de-emphasis step: 0 = 0 dB up to 14 = -15 dB, ordered by strength
  // for one code, range 1 is the weaker of the two settings, so it gets
  // the odd step and range 0 the even step above it; code 0 ignores range
  // a single ordered number lets the driver pick its taps with one compare
  function [3:0] deemph_step;
    input [3:0] sel; // {range, code}
    begin
      if (sel[2:0] == 3'h0) begin
        deemph_step = 4'h0;
      end else begin // fourteen distinct steps, 1..14
        deemph_step = {sel[2:0], 1'b0} - {3'h0, sel[3]};
      end
    end
  endfunction

  // shared select register, always reached at 0xff
  // a write to 0xff never lands in a channel set, whatever select holds,
  // so the host can always get back out of broadcast mode
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      select_ff <= `RTCFG_RST_SELECT;
    end else if (wr_en_i && addr_i == `RTCFG_ADDR_SELECT) begin
      select_ff <= wdata_i;
    end
  end

  // channel write; refused while the shared space is selected
  wire ch_wr = wr_en_i & chan_space & (addr_i != `RTCFG_ADDR_SELECT);
  // boost table window, 32 entries
  wire in_table = (addr_i >= `RTCFG_ADDR_TABLE_LO) && (addr_i <= `RTCFG_ADDR_TABLE_HI);
  // the window base is 32-aligned, so the low address bits are the entry
  wire [4:0] tbl_idx = addr_i[4:0];

  // channel address map kept here:
  //   0x00 reset strobe, reads zero
  //   tx_deemphasis_control de-emphasis, tx_swing_control output swing
  //   adapt_start_override_control override enable, adapt_start_index start index
  //   0x40 to 0x5f boost candidates
  // any other channel address reads zero and drops writes

  wire [8*NCH-1:0] rd_ch; // per channel read value
  genvar g; // channel number
  // one full register set per channel; nothing is shared between channels,
  // so every channel can be tuned on its own
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      reg [7:0] deemph_ff;
      reg [7:0] swing_ff; // output swing register
      reg [7:0] ovr_ff; // start index override control
      reg [7:0] idx_ff; // programmed start index
      reg [7:0] table_ff [0:31]; // boost candidates
      reg [7:0] rd_v; // read value of this channel
      integer k; // table entry loop
      // this channel is addressed alone or by broadcast
      wire hit = ch_wr & (bcast | (cur_ch == g));
      // reset strobe: bit 2 written to 0x00; the bit itself is never stored
      wire ch_rst = hit && addr_i == `RTCFG_ADDR_CH_RESET && wdata_i[`RTCFG_BIT_CH_RESET];
      // config registers; channel reset restores them too, bit is self-clearing
      // reset values are all zero: 0.6 V swing, no de-emphasis, no override
      // whole bytes are stored, so a host read-modify-write round-trips
      always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          deemph_ff <= `RTCFG_RST_REG;
          swing_ff <= `RTCFG_RST_REG;
          ovr_ff <= `RTCFG_RST_REG;
          idx_ff <= `RTCFG_RST_REG;
        end else if (ch_rst) begin
          deemph_ff <= `RTCFG_RST_REG;
          swing_ff <= `RTCFG_RST_REG;
          ovr_ff <= `RTCFG_RST_REG;
          idx_ff <= `RTCFG_RST_REG;
        end else if (hit) begin
          case (addr_i)
            `RTCFG_ADDR_DEEMPH: deemph_ff <= wdata_i;
            `RTCFG_ADDR_SWING: swing_ff <= wdata_i;
            `RTCFG_ADDR_OVR_CTRL: ovr_ff <= wdata_i;
            `RTCFG_ADDR_START_IDX: idx_ff <= wdata_i;
            default: ;
          endcase
        end
      end
      // boost table; no async reset on an array, so power-up restore is clocked
      // this is why reset must be held across at least one clock edge
      // host writes land only in the addressed entry of the hit channel
      always @(posedge ref_clk_i) begin
        for (k = 0; k < 32; k = k + 1) begin
          if (!resetn_i || ch_rst) begin
            table_ff[k] <= dflt_boost(k[4:0]);
          end else if (hit && in_table && tbl_idx == k[4:0]) begin
            table_ff[k] <= wdata_i;
          end
        end
      end
      // read mux for this channel; undocumented addresses read zero
      // the table window is tested first; it never overlaps the config registers
      always @* begin
        rd_v = 8'h00;
        if (in_table) begin
          rd_v = table_ff[tbl_idx];
        end else begin
          case (addr_i)
            `RTCFG_ADDR_DEEMPH: rd_v = deemph_ff;
            `RTCFG_ADDR_SWING: rd_v = swing_ff;
            `RTCFG_ADDR_OVR_CTRL: rd_v = ovr_ff;
            `RTCFG_ADDR_START_IDX: rd_v = idx_ff;
            default: rd_v = 8'h00;
          endcase
        end
      end
      // packed per channel so the shared read path can index it
      assign rd_ch[8*g +: 8] = rd_v;
      // derived per channel outputs, registered
      // they trail the registers by one clock: a write shows two edges later
      // start index falls back to entry 0 while the override is clear
      wire [4:0] sidx = ovr_ff[`RTCFG_BIT_OVR_EN] ? idx_ff[`RTCFG_START_IDX_MSB:0]
                                                 : `RTCFG_DEFAULT_START_IDX;
      // range bit on top, then the three code bits
      wire [3:0] dsel = {deemph_ff[`RTCFG_BIT_DEEMPH_RANGE], deemph_ff[`RTCFG_DEM_MSB:0]};
      // reset drives every derived output to zero at once, so the driver
      // sees 0.6 V swing and no de-emphasis until software writes
      always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          start_idx_o[5*g +: 5] <= 5'h00;
          start_boost_o[8*g +: 8] <= 8'h00;
          swing_code_o[3*g +: 3] <= 3'h0;
          deemph_sel_o[4*g +: 4] <= 4'h0;
          deemph_step_o[4*g +: 4] <= 4'h0;
        end else begin
          start_idx_o[5*g +: 5] <= sidx;
          start_boost_o[8*g +: 8] <= table_ff[sidx];
          swing_code_o[3*g +: 3] <= swing_ff[`RTCFG_SWING_MSB:0];
          deemph_sel_o[4*g +: 4] <= dsel;
          deemph_step_o[4*g +: 4] <= deemph_step(dsel);
        end
      end
    end
  endgenerate

  // read data: select reg always, else channel or shared space
  // answers the address of the previous cycle, one clock of latency
  // broadcast does not apply to reads: only the selected channel answers
  // shared registers other than the select are not kept here and read zero
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else if (addr_i == `RTCFG_ADDR_SELECT) begin
      rdata_o <= select_ff;
    end else if (chan_space) begin
      rdata_o <= rd_ch[8*cur_ch +: 8];
    end else begin
      rdata_o <= 8'h00; // shared set outside this block reads zero
    end
  end

endmodule
`default_nettype wire

// ### verification/rtcfg_properties.sv
// port assertions for the channel config register bank
`timescale 1ns/1ps
`default_nettype none
module rtcfg_chk #(parameter int NCH = 4) (
  input wire logic ref_clk_i, // clock
  input wire logic resetn_i, // reset, low
  input wire logic wr_en_i, // write strobe
  input wire logic [7:0] addr_i, // address
  input wire logic [7:0] wdata_i, // write data
  input wire logic [7:0] rdata_o, // read data
  input wire logic [3*NCH-1:0] swing_code_o, // swing codes
  input wire logic [4*NCH-1:0] deemph_sel_o, // range and code
  input wire logic [4*NCH-1:0] deemph_step_o // strength steps
);
  logic [7:0] sel_ff; // shadow of select, the real one is not a port
  always_ff @(posedge ref_clk_i or negedge resetn_i)
    if (!resetn_i) sel_ff <= 8'h00;
    else if (wr_en_i && addr_i == 8'hff) sel_ff <= wdata_i;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  a_swing_write: assert property (wr_en_i && sel_ff[3:0] == 4'h4 && addr_i == 8'h2d
    |-> ##2 swing_code_o[2:0] == $past(wdata_i[2:0], 2)) else $error("swing not taken");
  a_deemph_write: assert property (wr_en_i && sel_ff[3:0] == 4'h4 && addr_i == 8'h15
    |-> ##2 deemph_sel_o[3:0] == $past({wdata_i[6], wdata_i[2:0]}, 2)) else $error("dem");
  a_step_map: assert property (deemph_step_o[3:0] == (deemph_sel_o[2:0] == 3'h0 ?
    4'h0 : {deemph_sel_o[2:0] - {2'h0, deemph_sel_o[3]}, deemph_sel_o[3]}))
    else $error("step map");
  a_step_max: assert property (deemph_step_o[4*NCH-1 -: 4] != 4'hf)
    else $error("step out of range");
  a_shared_zero: assert property (!sel_ff[2] && addr_i != 8'hff |=> rdata_o == 8'h00)
    else $error("shared read not zero");
  a_reg0_zero: assert property (sel_ff[2] && addr_i == 8'h00 |=> rdata_o == 8'h00)
    else $error("reset reg not zero");
  a_undoc_zero: assert property (sel_ff[2] && addr_i == 8'h01 |=> rdata_o == 8'h00)
    else $error("reserved read not zero");
  a_read_back: assert property (sel_ff[3:0] == 4'h4 && addr_i == 8'h2d && !wr_en_i
    && !$past(wr_en_i) |=> rdata_o[2:0] == swing_code_o[2:0]) else $error("readback");
  c_bcast: cover property (wr_en_i && sel_ff[3:2] == 2'b11);
  c_ch_reset: cover property (wr_en_i && sel_ff[2] && addr_i == 8'h00 && wdata_i[2]);
  c_refused: cover property (wr_en_i && !sel_ff[2] && addr_i == 8'h2d);
endmodule
bind rtcfg_regs rtcfg_chk #(.NCH(NCH)) u_rtcfg_chk (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
  .wr_en_i(wr_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
  .swing_code_o(swing_code_o), .deemph_sel_o(deemph_sel_o), .deemph_step_o(deemph_step_o));
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the channel config register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk_i = 1'b0, resetn_i = 1'b0, wr_en_i = 1'b0; // clock, reset, strobe
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o; // register bus
  logic [19:0] idx; // start index per channel
  logic [31:0] boost; // boost entry per channel
  logic [11:0] swing; // swing codes, ch3 down to ch0
  logic [15:0] dsel, step; // de-emphasis per channel
  logic [7:0] v; // value read back
  int err_count = 0, checks = 0, cyc = 0; // tallies
  // rows: {addr, data, swing of all channels, ch0 step}
  logic [31:0] rows [18] = '{32'hff040000, 32'h2d050050, 32'h2dff0070, 32'h2f000070,
    32'h15400070, 32'h15010072, 32'h15410071, 32'h1546007b, 32'h1507007e, 32'h15c7007d,
    32'hff0c007d, 32'h2d02492d, 32'hff05492d, 32'h2d0349ad, 32'h150049ad, 32'hff0049ad,
    32'h2d0549ad, 32'hff0449ad};
  rtcfg_regs #(.NCH(4)) u_rtcfg_regs (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .wr_en_i(wr_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .start_idx_o(idx), .start_boost_o(boost), .swing_code_o(swing),
    .deemph_sel_o(dsel), .deemph_step_o(step));
  initial forever #4 ref_clk_i = ~ref_clk_i;
  // a hang counts as a mismatch
  always @(posedge ref_clk_i) if (++cyc == 1000) results(1);
  task automatic results(input int t);
    err_count += t;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, s);
    checks++;
    err_count += (s !== e);
    if (s !== e) $display("ERROR %s expected %h seen %h", n, e, s);
  endtask
  // derived outputs settle one edge after the write edge
  task automatic wr(input logic [7:0] a, d);
    @(negedge ref_clk_i) {wr_en_i, addr_i, wdata_i} = {1'b1, a, d};
    @(negedge ref_clk_i) wr_en_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
  endtask
  // read data stands one edge after the address is presented
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_i) addr_i = a;
    @(negedge ref_clk_i) d = rdata_o;
  endtask
  initial begin
    repeat (2) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    chk("reset", 16'h0000, {15'h0000, |{idx, boost, swing, dsel, step}});
    foreach (rows[i]) begin
      wr(rows[i][31:24], rows[i][23:16]);
      chk("swing step", rows[i][15:0], {swing, step[3:0]});
    end
    wr(8'h39, 8'h1f);
    chk("idx", 16'h0000, {11'h000, idx[4:0]});
    wr(8'h2f, 8'h08);
    chk("idx boost", 16'h1fa5, {3'h0, idx[4:0], boost[7:0]});
    wr(8'h5f, 8'h3c);
    chk("boost", 16'h003c, {8'h00, boost[7:0]});
    wr(8'h00, 8'h04);
    chk("ch reset", 16'h4980, {swing, step[3:0]});
    wr(8'h2f, 8'h08);
    wr(8'h39, 8'h1f);
    chk("boost", 16'h1fa5, {3'h0, idx[4:0], boost[7:0]});
    // read-modify-write of the range bit only, code bits kept
    wr(8'h15, 8'h47);
    rd(8'h15, v);
    chk("rmw read", 16'h0047, {8'h00, v});
    wr(8'h15, v & 8'hbf);
    chk("rmw sel step", 16'h007e, {8'h00, dsel[3:0], step[3:0]});
    rd(8'h01, v);
    chk("reserved read", 16'h0000, {8'h00, v});
    // a reset in mid-run must reload the boost table like power-up
    wr(8'h5f, 8'h3c);
    @(negedge ref_clk_i) resetn_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    chk("mid reset", 16'h0000, {15'h0000, |{idx, boost, swing, dsel, step, rdata_o}});
    resetn_i = 1'b1;
    wr(8'hff, 8'h04);
    wr(8'h2f, 8'h08);
    wr(8'h39, 8'h1f);
    chk("power-up table", 16'h1fa5, {3'h0, idx[4:0], boost[7:0]});
    results(0);
  end
endmodule
`default_nettype wire
